// ---- shared/lsct_pkg.sv ----
// Package: register map, descriptor fields and states of the local cycle engine
//
// How it works
// - Burst only with burst enable and nonzero prefetch count
// - Ready input enable selects ready input or counts
// - Terminate input off: bursts capped at four words
// - Prefetch count enabled: 00 single, 4/8/16 words
// - Prefetch count disabled: read until transaction stopped
// - Read address-to-data waits 0-31 before first read
// - Read data-to-data waits 0-3 between burst reads
// - Data-to-address waits 0-3, bus not driven then
// - Write address-to-data waits 0-31, data driven throughout
// - Write data-to-data waits 0-3 between burst writes
// - Bus width field: 8, 16, 32 bits, reset 32
// - Byte ordering bit: 1 big, 0 little endian
// - Big endian lane mode picks upper or lower lanes
// - Read strobe delay, asserted only if within read waits
// - Write strobe delay, asserted only if within write waits
// - Write hold clocks after write strobe deasserts
package lsct_pkg;

    localparam int APB_AW = 8;
    localparam int FIFO_DEPTH = 4;

    // Register byte offsets
    localparam logic [APB_AW-1:0] REG_DESC = 8'h00;
    localparam logic [APB_AW-1:0] REG_ADDR = 8'h04;
    localparam logic [APB_AW-1:0] REG_CMD = 8'h08;
    localparam logic [APB_AW-1:0] REG_STATUS = 8'h0C;
    localparam logic [APB_AW-1:0] REG_WDATA = 8'h10;
    localparam logic [APB_AW-1:0] REG_RDATA = 8'h14;

    // Descriptor fields
    localparam int D_BURST_EN = 0;
    localparam int D_READY_EN = 1;
    localparam int D_TERM_EN = 2;
    localparam int D_PF_CNT_LSB = 3;
    localparam int D_PF_EN = 5;
    localparam int D_RD_A2D_LSB = 6;
    localparam int D_RD_D2D_LSB = 11;
    localparam int D_D2A_LSB = 13;
    localparam int D_WR_A2D_LSB = 15;
    localparam int D_WR_D2D_LSB = 20;
    localparam int D_WIDTH_LSB = 22;
    localparam int D_BIG_END = 24;
    localparam int D_LANE_HI = 25;
    localparam int D_RD_SDLY_LSB = 26;
    localparam int D_WR_SDLY_LSB = 28;
    localparam int D_WR_HOLD_LSB = 30;
    localparam logic [31:0] DESC_RESET = 32'h0080_0000;

    // Command fields
    localparam int C_START = 0;
    localparam int C_WRITE = 1;
    localparam int C_STOP = 2;
    localparam int C_LEN_LSB = 4;
    localparam int C_BE_LSB = 8;

    // Bus width codes
    localparam logic [1:0] WIDTH_8 = 2'h0;
    localparam logic [1:0] WIDTH_16 = 2'h1;

    // Burst and prefetch lengths in words
    localparam logic [4:0] TERM_OFF_MAX_BEATS = 5'h04;
    localparam logic [4:0] PF_WORDS_0 = 5'h01;
    localparam logic [4:0] PF_WORDS_1 = 5'h04;
    localparam logic [4:0] PF_WORDS_2 = 5'h08;
    localparam logic [4:0] PF_WORDS_3 = 5'h10;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_A2D,
        ST_DATA,
        ST_D2D,
        ST_HOLD,
        ST_D2A
    } lsct_state_e;

endpackage

// ---- design/lsct_fifo.sv ----
// Module: small synchronous FIFO with valid/ready on both sides
module lsct_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] count;
    } lsct_fifo_s;

    lsct_fifo_s q, d;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////////////
    // Honest flags: full refuses pushes, empty shows no valid word
    assign inReady = q.count != FULL;
    assign outValid = q.count != '0;
    assign outData = q.mem[q.rp];
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    // Pointer wrap by compare so any depth works
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wp] = inData;
            d.wp = (q.wp == LAST) ? '0 : q.wp + AW'(1);
        end
        if (pop)
        begin
            d.rp = (q.rp == LAST) ? '0 : q.rp + AW'(1);
        end
        d.count = q.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

endmodule

// ---- design/lsct_local_cycle.sv ----
// Module: local bus cycle engine for one local space, with APB register access
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
module lsct_local_cycle (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [lsct_pkg::APB_AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] muxedLocalAddrDataBusIn,
    output logic [31:0] muxedLocalAddrDataBusOut,
    output logic muxedLocalAddrDataBusOe_n,
    output logic addrLatch,
    output logic rdStrobe_n,
    output logic wrStrobe_n,
    output logic [3:0] byteEnable_n,
    input wire logic localReadyInput_n,
    input wire logic burstTerminateInput_n
);
    import lsct_pkg::*;

    typedef struct packed {
        logic [31:0] desc;
        logic [31:0] baseAddr;
        logic [3:0] cmdLen;
        logic [3:0] cmdBe;
        logic busy;
        logic isWrite;
        logic stopReq;
        logic unlimited;
        logic strobeOk;
        lsct_state_e st;
        logic [4:0] left;
        logic [4:0] seg;
        logic [4:0] cnt;
        logic [2:0] cyc;
        logic [3:0] beSel;
        logic [31:0] curAddr;
        logic [31:0] busIn1;
        logic [31:0] busIn2;
        logic rdy1;
        logic rdy2;
        logic term1;
        logic term2;
        logic [31:0] busOut;
        logic busOe_n;
        logic ale;
        logic rdStb_n;
        logic wrStb_n;
        logic [3:0] be_n;
        logic [31:0] rdReg;
    } lsct_ctl_s;

    lsct_ctl_s q, d;

    logic [31:0] wrFifoData, rdFifoData, rdPushData;
    logic wrFifoInReady, wrFifoValid, wrPop, rdFifoReady, rdFifoValid, rdPush, rdPop;
    logic apbAccess, apbSetup, wrHit, mapped, fifoErr;
    logic [4:0] a2dWaits;
    logic [1:0] d2dWaits, d2aWaits, holdClks, strobeDly, busWidth;
    logic burstOk, readyOk, termHit, segFull, beatOk, more, contBurst, strobePhase, rdSettled;
    logic [2:0] addrInc;

    ////////////////////////////////////////////////////////////////////////////////
    // Lane placement helpers

    // Software word to bus lanes for the configured width and ordering
    function automatic logic [31:0] mapLanes(input logic [31:0] v, input logic [1:0] w,
                                             input logic big, input logic hi);
        logic [15:0] h;
        h = {v[7:0], v[15:8]};
        if (!big)
            return v;
        else if (w == WIDTH_8)
            return hi ? {v[7:0], 24'h00_0000} : {24'h00_0000, v[7:0]};
        else if (w == WIDTH_16)
            return hi ? {h, 16'h0000} : {16'h0000, h};
        else
            return {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    // Bus lanes back to a right-aligned software word
    function automatic logic [31:0] unmapLanes(input logic [31:0] v, input logic [1:0] w,
                                               input logic big, input logic hi);
        logic [15:0] h;
        h = hi ? v[31:16] : v[15:0];
        if (w == WIDTH_8)
            return {24'h00_0000, (big && hi) ? v[31:24] : v[7:0]};
        else if (w == WIDTH_16)
            return big ? {16'h0000, h[7:0], h[15:8]} : {16'h0000, v[15:0]};
        else if (big)
            return {v[7:0], v[15:8], v[23:16], v[31:24]};
        else
            return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Data buffers: APB writes fill one, local reads fill the other

    lsct_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) wrFifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inData(pwdata),
        .inValid(wrHit),
        .inReady(wrFifoInReady),
        .outData(wrFifoData),
        .outValid(wrFifoValid),
        .outReady(wrPop)
    );

    lsct_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) rdFifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .inData(rdPushData),
        .inValid(rdPush),
        .inReady(rdFifoReady),
        .outData(rdFifoData),
        .outValid(rdFifoValid),
        .outReady(rdPop)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, errors on unmapped or blocked FIFO access
    assign apbAccess = psel && penable;
    assign apbSetup = psel && !penable;
    assign mapped = paddr inside {REG_DESC, REG_ADDR, REG_CMD, REG_STATUS, REG_WDATA, REG_RDATA};
    assign fifoErr = (pwrite && paddr == REG_WDATA && !wrFifoInReady)
                  || (!pwrite && paddr == REG_RDATA && !rdFifoValid);
    assign pready = 1'b1;
    assign pslverr = apbAccess && (!mapped || fifoErr);
    assign prdata = q.rdReg;
    assign wrHit = apbAccess && pwrite && paddr == REG_WDATA;
    assign rdPop = apbAccess && !pwrite && paddr == REG_RDATA && rdFifoValid;

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor decode for the cycle in progress
    assign a2dWaits = q.isWrite ? q.desc[D_WR_A2D_LSB +: 5] : q.desc[D_RD_A2D_LSB +: 5];
    assign d2dWaits = q.isWrite ? q.desc[D_WR_D2D_LSB +: 2] : q.desc[D_RD_D2D_LSB +: 2];
    assign d2aWaits = q.desc[D_D2A_LSB +: 2];
    assign holdClks = q.desc[D_WR_HOLD_LSB +: 2];
    assign strobeDly = q.isWrite ? q.desc[D_WR_SDLY_LSB +: 2] : q.desc[D_RD_SDLY_LSB +: 2];
    assign busWidth = q.desc[D_WIDTH_LSB +: 2];
    assign burstOk = q.desc[D_BURST_EN] && q.desc[D_PF_CNT_LSB +: 2] != 2'h0;
    assign readyOk = !q.desc[D_READY_EN] || !q.rdy2;
    assign termHit = q.desc[D_TERM_EN] && !q.term2;
    assign segFull = !q.desc[D_TERM_EN] && (q.seg + 5'h01) >= TERM_OFF_MAX_BEATS;
    // Write beats need a buffered word, read beats need room to store one
    assign beatOk = readyOk && (q.isWrite ? wrFifoValid : rdSettled && rdFifoReady);
    // Read data needs pin lag, partner reply and two sync flops before it is seen
    assign rdSettled = q.cnt >= 5'h05;
    assign more = !q.stopReq && (q.unlimited || q.left > 5'h01);
    assign contBurst = more && burstOk && !termHit && !segFull;
    assign addrInc = (busWidth == WIDTH_8) ? 3'h1 : (busWidth == WIDTH_16) ? 3'h2 : 3'h4;
    assign wrPop = q.st == ST_DATA && q.isWrite && beatOk;
    assign rdPush = q.st == ST_DATA && !q.isWrite && beatOk;
    assign rdPushData = unmapLanes(q.busIn2, busWidth, q.desc[D_BIG_END], q.desc[D_LANE_HI]);
    // Strobe only when its delay fits inside the address-to-data waits
    assign strobePhase = q.strobeOk && q.cyc >= {1'b0, strobeDly}
                      && q.st inside {ST_A2D, ST_DATA, ST_D2D};

    ////////////////////////////////////////////////////////////////////////////////
    // Registers, synchronisers, cycle sequencer and registered pin drive
    always_comb
    begin
        d = q;

        // Pins cross two flops before anything looks at them
        d.busIn1 = muxedLocalAddrDataBusIn;
        d.busIn2 = q.busIn1;
        d.rdy1 = localReadyInput_n;
        d.rdy2 = q.rdy1;
        d.term1 = burstTerminateInput_n;
        d.term2 = q.term1;

        // Read data captured in setup so it stands through the access phase
        if (apbSetup && !pwrite)
        begin
            case (paddr)
                REG_DESC: d.rdReg = q.desc;
                REG_ADDR: d.rdReg = q.baseAddr;
                REG_CMD: d.rdReg = {20'h0_0000, q.cmdBe, q.cmdLen, 4'h0};
                REG_STATUS: d.rdReg = {25'h000_0000, q.st, q.stopReq, rdFifoValid,
                                       !wrFifoInReady, q.busy};
                REG_RDATA: d.rdReg = rdFifoValid ? rdFifoData : 32'h0000_0000;
                default: d.rdReg = 32'h0000_0000;
            endcase
        end

        // Register writes; start is ignored while a transaction runs
        if (apbAccess && pwrite)
        begin
            case (paddr)
                REG_DESC: d.desc = pwdata;
                REG_ADDR: d.baseAddr = pwdata;
                REG_CMD:
                begin
                    d.cmdLen = pwdata[C_LEN_LSB +: 4];
                    d.cmdBe = pwdata[C_BE_LSB +: 4];
                    if (pwdata[C_STOP] && q.busy)
                        d.stopReq = 1'b1;
                    if (pwdata[C_START] && !q.busy)
                    begin
                        d.busy = 1'b1;
                        d.stopReq = 1'b0;
                        d.isWrite = pwdata[C_WRITE];
                        d.curAddr = q.baseAddr;
                        d.unlimited = 1'b0;
                        d.beSel = ~pwdata[C_BE_LSB +: 4];
                        if (pwdata[C_WRITE])
                            d.left = {1'b0, pwdata[C_LEN_LSB +: 4]} + 5'h01;
                        else if (!q.desc[D_PF_EN])
                        begin
                            d.unlimited = 1'b1;
                            d.beSel = 4'h0;
                        end
                        else
                        begin
                            // Count 00 reads only the requested bytes
                            case (q.desc[D_PF_CNT_LSB +: 2])
                                2'h0: d.left = PF_WORDS_0;
                                2'h1: d.left = PF_WORDS_1;
                                2'h2: d.left = PF_WORDS_2;
                                default: d.left = PF_WORDS_3;
                            endcase
                            if (q.desc[D_PF_CNT_LSB +: 2] != 2'h0)
                                d.beSel = 4'h0;
                        end
                    end
                end
                default: ;
            endcase
        end

        // Cycle counter from the start of each address phase, saturating
        d.cyc = (q.cyc == 3'h4) ? q.cyc : q.cyc + 3'h1;

        case (q.st)
            ST_IDLE:
            begin
                // A write waits for its first word so data is valid in the waits
                if (q.busy && (!q.isWrite || wrFifoValid))
                    d.st = ST_ADDR;
                else if (q.busy && q.stopReq)
                    d.busy = 1'b0;
            end
            ST_ADDR:
            begin
                d.seg = 5'h00;
                d.strobeOk = {3'h0, strobeDly} <= a2dWaits;
                d.cnt = 5'h01;
                d.st = (a2dWaits == 5'h00) ? ST_DATA : ST_A2D;
            end
            ST_A2D, ST_D2D:
            begin
                d.cnt = q.cnt + 5'h01;
                if (q.st == ST_A2D ? q.cnt >= a2dWaits : q.cnt >= {3'h0, d2dWaits})
                begin
                    d.st = ST_DATA;
                    d.cnt = 5'h01;
                end
            end
            ST_DATA:
            begin
                if (beatOk)
                begin
                    d.left = q.left - 5'h01;
                    d.seg = q.seg + 5'h01;
                    d.curAddr = q.curAddr + {29'h0000_0000, addrInc};
                    d.cnt = 5'h01;
                    if (contBurst)
                        d.st = (d2dWaits == 2'h0) ? ST_DATA : ST_D2D;
                    else if (q.isWrite && holdClks != 2'h0)
                        d.st = ST_HOLD;
                    else if (d2aWaits != 2'h0)
                        d.st = ST_D2A;
                    else
                    begin
                        d.st = more ? ST_IDLE : ST_IDLE;
                        d.busy = more;
                    end
                end
                else if (q.cnt != 5'h1F)
                    d.cnt = q.cnt + 5'h01;
            end
            ST_HOLD:
            begin
                d.cnt = q.cnt + 5'h01;
                if (q.cnt >= {3'h0, holdClks})
                begin
                    d.cnt = 5'h01;
                    d.st = (d2aWaits != 2'h0) ? ST_D2A : ST_IDLE;
                    if (d2aWaits == 2'h0)
                        d.busy = !q.stopReq && (q.unlimited || q.left != 5'h00);
                end
            end
            ST_D2A:
            begin
                d.cnt = q.cnt + 5'h01;
                if (q.cnt >= {3'h0, d2aWaits})
                begin
                    d.st = ST_IDLE;
                    d.busy = !q.stopReq && (q.unlimited || q.left != 5'h00);
                end
            end
            default: d.st = ST_IDLE;
        endcase
        if (d.st == ST_ADDR)
            d.cyc = 3'h0;

        // Pins follow the present state one clock later
        d.ale = q.st == ST_ADDR;
        d.busOe_n = !(q.st == ST_ADDR
                   || (q.isWrite && q.st inside {ST_A2D, ST_DATA, ST_D2D, ST_HOLD}));
        d.busOut = (q.st == ST_ADDR) ? q.curAddr
                 : mapLanes(wrFifoData, busWidth, q.desc[D_BIG_END], q.desc[D_LANE_HI]);
        d.rdStb_n = !(strobePhase && !q.isWrite);
        d.wrStb_n = !(strobePhase && q.isWrite);
        d.be_n = (q.st == ST_IDLE) ? 4'hF : q.beSel;
    end

    // One register stage holds every piece of state except the storage, pointers and counts of the two FIFOs
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            q <= '0;
            q.desc <= DESC_RESET;
            q.st <= ST_IDLE;
            q.busOe_n <= 1'b1;
            q.rdStb_n <= 1'b1;
            q.wrStb_n <= 1'b1;
            q.be_n <= 4'hF;
            q.rdy1 <= 1'b1;
            q.rdy2 <= 1'b1;
            q.term1 <= 1'b1;
            q.term2 <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Local bus pins
    assign muxedLocalAddrDataBusOut = q.busOut;
    assign muxedLocalAddrDataBusOe_n = q.busOe_n;
    assign addrLatch = q.ale;
    assign rdStrobe_n = q.rdStb_n;
    assign wrStrobe_n = q.wrStb_n;
    assign byteEnable_n = q.be_n;

endmodule

// ---- tb/lsct_local_cycle_properties.sv ----
// Checker: local bus pin timing of the cycle engine
module lsct_local_cycle_properties (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic muxedLocalAddrDataBusOe_n,
    input wire logic addrLatch,
    input wire logic rdStrobe_n,
    input wire logic wrStrobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic [5:0] sinceLatch_q;
    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the address phase; saturates so a strobe with no address fails
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            sinceLatch_q <= 6'h3F;
        else if (addrLatch)
            sinceLatch_q <= 6'h01;
        else if (sinceLatch_q != 6'h3F)
            sinceLatch_q <= sinceLatch_q + 6'h01;
    end
    sequence addrPhase;
        addrLatch && !muxedLocalAddrDataBusOe_n;
    endsequence
    sequence quietPins;
        muxedLocalAddrDataBusOe_n && rdStrobe_n && wrStrobe_n && !addrLatch;
    endsequence
    addr_phase_a: assert property (addrLatch |-> addrPhase ##1 !addrLatch)
        else $error("address phase malformed");
    read_release_a: assert property (!rdStrobe_n |-> muxedLocalAddrDataBusOe_n)
        else $error("bus driven during read strobe");
    write_drive_a: assert property (!wrStrobe_n |-> !muxedLocalAddrDataBusOe_n)
        else $error("write data not driven under strobe");
    strobe_excl_a: assert property (rdStrobe_n || wrStrobe_n)
        else $error("both strobes asserted");
    latch_idle_a: assert property (addrLatch |-> rdStrobe_n && wrStrobe_n)
        else $error("strobe asserted in address phase");
    rd_delay_a: assert property ($fell(rdStrobe_n) |-> sinceLatch_q inside {[1:4]})
        else $error("read strobe delay out of range");
    wr_delay_a: assert property ($fell(wrStrobe_n) |-> sinceLatch_q inside {[1:4]})
        else $error("write strobe delay out of range");
    reset_quiet_a: assert property (disable iff (1'b0) sys_rst |=> quietPins)
        else $error("pins active after reset");
endmodule
bind lsct_local_cycle lsct_local_cycle_properties checkProps (
    .clk_sys, .sys_rst, .muxedLocalAddrDataBusOe_n, .addrLatch, .rdStrobe_n, .wrStrobe_n
);

// ---- tb/lsct_local_mem.sv ----
// Partner: local bus memory answering the cycle engine
module lsct_local_mem (
    input wire logic clk_sys,
    input wire logic [31:0] busOut,
    input wire logic addrLatch,
    input wire logic rdStrobe_n,
    input wire logic wrStrobe_n,
    input wire logic holdReady,
    output logic [31:0] busIn,
    output logic localReadyInput_n,
    output logic burstTerminateInput_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:63];
    logic [31:0] latchAddr_q = 32'h0;
    logic [1:0] holdCnt_q = 2'h0;
    initial
    begin
        busIn = 32'h0;
        localReadyInput_n = 1'b1;
        burstTerminateInput_n = 1'b1; // Never asks to end a burst early
        for (int i = 0; i < 64; i++)
            mem[i] = 32'hC0DE_0000 | 32'(i);
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Latch address, store writes, drive reads with a short output hold
    always @(posedge clk_sys)
    begin
        if (addrLatch)
            latchAddr_q <= busOut;
        if (!wrStrobe_n)
            mem[latchAddr_q[7:2]] <= busOut;
        if (!rdStrobe_n)
            holdCnt_q <= 2'h3;
        else if (holdCnt_q != 2'h0)
            holdCnt_q <= holdCnt_q - 2'h1;
        // Released bus inverts every clock, so a late sample matches only on alternate clocks
        busIn <= (!rdStrobe_n || holdCnt_q != 2'h0) ? mem[latchAddr_q[7:2]] : ~busIn;
        localReadyInput_n <= holdReady;
    end
endmodule

// ---- tb/test_local_space_cycle_timing.sv ----
// Testbench: register access and local cycle scenarios for the cycle engine
module test_local_space_cycle_timing;
    timeunit 1ns;
    timeprecision 1ps;
    import lsct_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [APB_AW-1:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic holdReady = 1'b0;
    logic [31:0] prdata, busOut, busIn, rdData;
    logic pready, pslverr, busOe_n, addrLatch, rdStrobe_n, wrStrobe_n, readyIn_n, termIn_n, rdErr;
    logic [3:0] byteEnable_n;
    int nMismatch = 0;
    int nCompared = 0;
    int nLatch = 0;
    int nRdLow = 0;
    lsct_local_cycle DUT (
        .clk_sys, .sys_rst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .muxedLocalAddrDataBusIn(busIn), .muxedLocalAddrDataBusOut(busOut),
        .muxedLocalAddrDataBusOe_n(busOe_n), .addrLatch, .rdStrobe_n, .wrStrobe_n,
        .byteEnable_n, .localReadyInput_n(readyIn_n), .burstTerminateInput_n(termIn_n)
    );
    lsct_local_mem localMem (
        .clk_sys, .busOut, .addrLatch, .rdStrobe_n, .wrStrobe_n, .holdReady, .busIn,
        .localReadyInput_n(readyIn_n), .burstTerminateInput_n(termIn_n)
    );
    always #12.5 clk_sys = ~clk_sys;
    // Address phases and read strobe cycles seen on the pins
    always @(posedge clk_sys)
    begin
        if (addrLatch === 1'b1)
            nLatch++;
        if (rdStrobe_n === 1'b0)
            nRdLow++;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One APB transfer; answer taken mid access phase
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(negedge clk_sys);
            rdData = prdata;
            rdErr = pslverr;
        end while (pready !== 1'b1);
        @(posedge clk_sys);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    end
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    begin
        nCompared++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Poll busy under a bound; a hang counts as a mismatch
    task automatic waitIdle;
    begin
        for (int i = 0; i < 400; i++)
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            if (rdData[0] === 1'b0)
                return;
        end
        nMismatch++;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testReset;
    begin
        apb(1'b0, REG_DESC, 32'h0);
        cmp(rdData, DESC_RESET);
        apb(1'b0, 8'h40, 32'h0);
        cmp({31'h0, rdErr}, 32'h1);
        cmp(rdData, 32'h0);
    end
    endtask
    // Write with waits, strobe delay and hold, then read it back with waits
    task automatic testWriteRead;
        logic [31:0] desc;
        int latch0;
    begin
        desc = DESC_RESET | (32'h2 << D_WR_A2D_LSB) | (32'h1 << D_WR_SDLY_LSB)
            | (32'h2 << D_WR_HOLD_LSB) | (32'h3 << D_RD_A2D_LSB) | (32'h2 << D_RD_SDLY_LSB)
            | (32'h1 << D_D2A_LSB) | (32'h1 << D_PF_EN);
        apb(1'b1, REG_DESC, desc);
        apb(1'b0, REG_DESC, 32'h0);
        cmp(rdData, desc);
        apb(1'b1, REG_WDATA, 32'h5A5A_1234);
        apb(1'b1, REG_ADDR, 32'h0000_0040);
        apb(1'b1, REG_CMD, 32'h0000_0F03);
        waitIdle();
        cmp(localMem.mem[16], 32'h5A5A_1234);
        latch0 = nLatch;
        apb(1'b1, REG_CMD, 32'h0000_0F01);
        waitIdle();
        apb(1'b0, REG_RDATA, 32'h0);
        cmp(rdData, 32'h5A5A_1234);
        cmp(32'(nLatch - latch0), 32'h1);
    end
    endtask
    // Strobe delay beyond the address-to-data waits: read strobe must stay off
    task automatic testStrobeRefused;
        int low0;
    begin
        apb(1'b1, REG_DESC, DESC_RESET | (32'h1 << D_RD_A2D_LSB) | (32'h3 << D_RD_SDLY_LSB)
            | (32'h1 << D_PF_EN));
        low0 = nRdLow;
        apb(1'b1, REG_CMD, 32'h0000_0F01);
        waitIdle();
        cmp(32'(nRdLow - low0), 32'h0);
        apb(1'b0, REG_RDATA, 32'h0);
    end
    endtask
    // Ready withheld: ignored when disabled, stalls the cycle when enabled
    task automatic testReady;
    begin
        apb(1'b1, REG_DESC, DESC_RESET | (32'h1 << D_PF_EN));
        holdReady <= 1'b1;
        apb(1'b1, REG_CMD, 32'h0000_0F01);
        waitIdle();
        apb(1'b0, REG_RDATA, 32'h0);
        cmp(rdData, 32'h5A5A_1234);
        apb(1'b1, REG_DESC, DESC_RESET | (32'h1 << D_PF_EN) | (32'h1 << D_READY_EN));
        apb(1'b1, REG_CMD, 32'h0000_0F01);
        repeat (30) @(posedge clk_sys);
        apb(1'b0, REG_STATUS, 32'h0);
        cmp({31'h0, rdData[0]}, 32'h1);
        holdReady <= 1'b0;
        waitIdle();
        apb(1'b0, REG_RDATA, 32'h0);
        cmp(rdData, 32'h5A5A_1234);
    end
    endtask
    // Every prefetch code with burst on, then burst off; words read and address phases counted
    task automatic testPrefetch;
        int words [5] = '{1, 4, 8, 16, 4};
        int latches [5] = '{1, 1, 2, 4, 4};
        int got, latch0;
    begin
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, REG_DESC, DESC_RESET | (32'h1 << D_PF_EN) | 32'(i < 4)
                | (32'(i % 4 + i / 4) << D_PF_CNT_LSB));
            latch0 = nLatch;
            got = 0;
            apb(1'b1, REG_CMD, 32'h0000_0F01);
            for (int t = 0; t < 300 && got < words[i]; t++)
            begin
                apb(1'b0, REG_RDATA, 32'h0);
                if (rdErr === 1'b0)
                    got++;
            end
            waitIdle();
            apb(1'b0, REG_RDATA, 32'h0);
            cmp(32'(got), 32'(words[i]));
            cmp({31'h0, rdErr}, 32'h1);
            cmp(32'(nLatch - latch0), 32'(latches[i]));
        end
    end
    endtask
    task automatic finalReport;
    begin
        if (nMismatch == 0 && nCompared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        testReset();
        testWriteRead();
        testStrobeRefused();
        testReady();
        testPrefetch();
        finalReport();
    end
    // Watchdog
    initial
    begin
        #500000;
        nMismatch++;
        finalReport();
    end
endmodule
